// *** lpa_pkg.sv ***
// Shared constants and types for the linefeed power alarm block.
// Assumes one 200 MHz clock and A/D samples already held as magnitudes.
package lpa_pkg;

  // Clock and power calculation rate
  localparam int unsigned CLOCK_HZ = 200_000_000;
  localparam int unsigned CALC_RATE_HZ = 800;
  localparam int unsigned TICK_CYCLES = CLOCK_HZ / CALC_RATE_HZ;
  localparam int unsigned TICK_W = 18;

  // Number of linefeed transistors
  localparam int unsigned NUM_Q = 6;

  // Software-visible locations (indices)
  localparam logic [2:0] LOC_TOTAL_SUM = 3'h0;
  localparam logic [2:0] LOC_THR12 = 3'h1;
  localparam logic [2:0] LOC_THR34 = 3'h2;
  localparam logic [2:0] LOC_THR56 = 3'h3;
  localparam logic [2:0] LOC_POLE12 = 3'h4;
  localparam logic [2:0] LOC_POLE34 = 3'h5;
  localparam logic [2:0] LOC_POLE56 = 3'h6;

  // Reset values: thresholds at maximum so no alarm before setup
  localparam logic [15:0] THR_RESET = 16'hffff;
  localparam logic [15:0] POLE_RESET = 16'h0080;

  // 0.75 V collector-emitter drop at 4.907 mV per LSB
  localparam logic [15:0] VCE_OFFSET = 16'h0099;

  // Product LSB is about 15.2 nW: 498 uW = 2^15, 31.1 uW = 2^11
  localparam int unsigned DISC_SHIFT = 15;
  localparam int unsigned LOW_SHIFT = 11;

  // 1059.6 uW per LSB: multiply by 2^32 / 69725 then drop 32 bits
  localparam logic [31:0] COMP_SCALE = 32'h0000f09f;
  localparam int unsigned COMP_SHIFT = 32;

  // Pole field: 12 bits plus sign in [15:3], full scale 4096
  localparam int unsigned POLE_MSB = 15;
  localparam int unsigned POLE_LSB = 3;
  localparam int unsigned POLE_FULL_SHIFT = 12;
  localparam int unsigned FILT_FRAC = 12;

  // One set of A/D values (magnitudes)
  typedef struct packed {
    logic [15:0] vtip;
    logic [15:0] vring;
    logic [15:0] vbat;
    logic [NUM_Q-1:0][15:0] cur;
  } lpa_sample_s;

endpackage

// *** lpa_power_calc.sv ***
// Per-transistor and total power estimates from one A/D sample set.
// Assumes the sample holds stable magnitudes while i_tick pulses.
`timescale 1ns/100ps
module lpa_power_calc
  import lpa_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire lpa_sample_s i_sample,
  output logic [NUM_Q-1:0][15:0] o_pow,
  output logic [15:0] o_total,
  output logic o_valid
);

  // Saturate a wide unsigned value to 16 bits
  function automatic logic [15:0] sat16(input logic [67:0] v);
    sat16 = (v[67:16] != '0) ? 16'hffff : v[15:0];
  endfunction

  // Subtraction that floors at zero
  function automatic logic [16:0] floor_sub(input logic [15:0] a, input logic [15:0] b);
    floor_sub = (a > b) ? {1'b0, a - b} : 17'h00000;
  endfunction

  logic [NUM_Q-1:0][16:0] vce;
  logic [NUM_Q-1:0][32:0] prod;
  logic [NUM_Q-1:0][15:0] pow_nxt;
  logic [35:0] sum_raw;
  logic [67:0] sum_scaled;
  logic [NUM_Q-1:0][15:0] pow_r;
  logic [15:0] total_r;
  logic valid_r;
  logic [15:0] total_nxt;

  // Voltage across each transistor
  always_comb
  begin
    vce[0] = {1'b0, i_sample.vtip} + {1'b0, VCE_OFFSET}; // RL1
    vce[1] = {1'b0, i_sample.vring} + {1'b0, VCE_OFFSET}; // RL1
    vce[2] = {1'b0, i_sample.vbat} + {1'b0, VCE_OFFSET}; // RL1
    vce[3] = {1'b0, i_sample.vbat} + {1'b0, VCE_OFFSET}; // RL1
    vce[4] = floor_sub(i_sample.vbat, i_sample.vring); // RL1
    vce[5] = floor_sub(i_sample.vbat, i_sample.vtip); // RL1
  end

  // Products and per-pair scaling; pair three-four uses the finer LSB
  genvar g;
  generate
    for (g = 0; g < NUM_Q; g++)
    begin : g_q
      assign prod[g] = vce[g] * i_sample.cur[g];
      assign pow_nxt[g] = (g == 2 || g == 3)
        ? sat16({35'h0, prod[g]} >> LOW_SHIFT)
        : sat16({35'h0, prod[g]} >> DISC_SHIFT); // RL15
    end
  endgenerate

  // Total of all six products, scaled to the companion LSB
  always_comb
  begin
    sum_raw = '0;
    for (int k = 0; k < NUM_Q; k++)
      sum_raw = sum_raw + {3'h0, prod[k]}; // RL2
    sum_scaled = {32'h0, sum_raw} * {36'h0, COMP_SCALE};
    total_nxt = sat16(sum_scaled >> COMP_SHIFT); // RL9
  end

  // Latch results once per calculation tick
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      pow_r <= '0;
      total_r <= '0;
      valid_r <= 1'b0;
    end
    else
    begin
      valid_r <= i_tick; // RL3
      if (i_tick)
      begin
        pow_r <= pow_nxt;
        total_r <= total_nxt;
      end
    end
  end

  assign o_pow = pow_r;
  assign o_total = total_r;
  assign o_valid = valid_r;

endmodule

// *** lpa_thermal_filter.sv ***
// First-order thermal low-pass on one power stream.
// Assumes i_update pulses once per new sample; pole read from [15:3].
`timescale 1ns/100ps
module lpa_thermal_filter
  import lpa_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_update,
  input wire logic [15:0] i_x,
  input wire logic [15:0] i_pole,
  output logic [15:0] o_y,
  output logic o_valid
);

  // Fraction bits keep small poles from stalling the output
  logic [27:0] acc_r;
  logic [27:0] acc_nxt;
  logic valid_r;
  logic signed [28:0] diff;
  logic signed [12:0] pole;
  logic signed [41:0] prod;
  logic signed [41:0] step;
  logic signed [29:0] sum;

  // y += pole * (x - y) / 4096
  always_comb
  begin
    pole = $signed(i_pole[POLE_MSB:POLE_LSB]); // RL4
    diff = $signed({1'b0, i_x, 12'h000}) - $signed({1'b0, acc_r});
    prod = diff * pole;
    step = prod >>> POLE_FULL_SHIFT; // RL17
    sum = $signed({2'b00, acc_r}) + step[29:0];
    acc_nxt = acc_r;
    if (i_update)
    begin
      if (sum < 0)
        acc_nxt = '0;
      else if (sum[29:28] != 2'b00)
        acc_nxt = '1;
      else
        acc_nxt = sum[27:0]; // RL17
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      acc_r <= '0;
      valid_r <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      valid_r <= i_update;
    end
  end

  assign o_y = acc_r[27:FILT_FRAC];
  assign o_valid = valid_r;

endmodule

// *** lpa_linefeed_power_alarm.sv ***
// Linefeed power monitor: power estimate, thermal filters, alarms, open state.
// Assumes samples come from same-clock logic; the sense pin is asynchronous.
//
// Overview of operation
// RL1: Companion mode estimates six transistor powers.
// RL2: Companion mode sums six powers into total.
// RL3: Recompute at 800 Hz, filter before compare.
// RL4: Pole is signed 13 bits in [15:3].
// RL5: Software programs pole from thermal time constant.
// RL6: Discrete mode: per-pair pole and threshold.
// RL7: Companion mode filters total with pair-one-two settings.
// RL8: Filtered total above threshold raises alarm.
// RL9: Sense pin selects coarser total power scaling.
// RL10: Any alarm forces line state open.
// RL11: Open persists until software write, masking ignored.
// RL12: Discrete alarms set own pending; enables gate.
// RL13: Companion alarm uses first pending and enable.
// RL14: Total power location is 16-bit read.
// RL15: Thresholds 16 bits; pair three-four finer LSB.
// RL16: Pending sets on rising edge, software clears.
// RL17: First-order recursive low-pass by pole times error.
// RL18: Compare strictly greater, once per update.
`timescale 1ns/100ps
module lpa_linefeed_power_alarm
  import lpa_pkg::*;
#(
  parameter int unsigned TICK_PERIOD = TICK_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire lpa_sample_s i_sample,
  input wire logic i_thermal_sense_pin,
  input wire logic i_loc_wr,
  input wire logic [2:0] i_loc_addr,
  input wire logic [15:0] i_loc_wdata,
  output logic [15:0] o_loc_rdata,
  input wire logic [NUM_Q-1:0] i_alarm_clear,
  input wire logic [NUM_Q-1:0] i_transistor_alarm_enable,
  output logic [NUM_Q-1:0] o_transistor_alarm_pending,
  output logic o_alarm_request,
  input wire logic i_line_state_write,
  output logic o_line_open,
  output logic o_companion_mode
);

  // Pick a pair setting from a transistor number
  function automatic int unsigned pair_of(input int unsigned q);
    pair_of = q / 2;
  endfunction

  // Calculation tick divider
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TICK_W-1:0] tick_cnt_nxt;
  logic tick;

  always_comb
  begin
    tick = (tick_cnt_r == TICK_W'(TICK_PERIOD - 1));
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1; // RL3
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_nxt;
  end

  // Two-stage synchroniser for the sense pin
  logic sense_meta_r;
  logic sense_sync_r;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      sense_meta_r <= 1'b0;
      sense_sync_r <= 1'b0;
    end
    else
    begin
      sense_meta_r <= i_thermal_sense_pin;
      sense_sync_r <= sense_meta_r;
    end
  end

  // Mode changes only at a tick so a filter never sees mixed scaling
  logic mode_r;
  logic mode_nxt;

  always_comb
  begin
    mode_nxt = tick ? sense_sync_r : mode_r; // RL9
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      mode_r <= 1'b0;
    else
      mode_r <= mode_nxt;
  end

  // Threshold and pole locations
  logic [2:0][15:0] thr_r;
  logic [2:0][15:0] thr_nxt;
  logic [2:0][15:0] pole_r;
  logic [2:0][15:0] pole_nxt;

  always_comb
  begin
    thr_nxt = thr_r;
    pole_nxt = pole_r;
    if (i_loc_wr)
    begin
      unique case (i_loc_addr)
        LOC_THR12: thr_nxt[0] = i_loc_wdata;
        LOC_THR34: thr_nxt[1] = i_loc_wdata; // RL15
        LOC_THR56: thr_nxt[2] = i_loc_wdata;
        LOC_POLE12: pole_nxt[0] = i_loc_wdata;
        LOC_POLE34: pole_nxt[1] = i_loc_wdata; // RL4
        LOC_POLE56: pole_nxt[2] = i_loc_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      thr_r <= {3{THR_RESET}};
      pole_r <= {3{POLE_RESET}};
    end
    else
    begin
      thr_r <= thr_nxt;
      pole_r <= pole_nxt;
    end
  end

  // Power estimation
  logic [NUM_Q-1:0][15:0] pow;
  logic [15:0] total;
  logic pow_valid;

  lpa_power_calc u_calc (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_sample(i_sample),
    .o_pow(pow),
    .o_total(total),
    .o_valid(pow_valid)
  );

  // One filter per transistor; filter zero takes the total in companion mode
  logic [NUM_Q-1:0][15:0] filt_y;
  logic [NUM_Q-1:0] filt_valid;
  logic [NUM_Q-1:0] over;

  genvar g;
  generate
    for (g = 0; g < NUM_Q; g++)
    begin : g_filt
      logic [15:0] x_in;
      if (g == 0)
      begin : g_first
        assign x_in = mode_r ? total : pow[0]; // RL7
      end
      else
      begin : g_rest
        assign x_in = pow[g];
      end
      lpa_thermal_filter u_filt (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_update(pow_valid), // RL3
        .i_x(x_in),
        .i_pole(pole_r[pair_of(g)]), // RL6
        .o_y(filt_y[g]),
        .o_valid(filt_valid[g])
      );
      // Unused filters in companion mode never compare high
      assign over[g] = (g == 0 || !mode_r)
        && (filt_y[g] > thr_r[pair_of(g)]); // RL18 RL6 RL8
    end
  endgenerate

  // Comparator state, pending bits and forced open line
  logic [NUM_Q-1:0] over_r;
  logic [NUM_Q-1:0] over_nxt;
  logic [NUM_Q-1:0] pend_r;
  logic [NUM_Q-1:0] pend_nxt;
  logic [NUM_Q-1:0] rise;
  logic open_r;
  logic open_nxt;

  always_comb
  begin
    over_nxt = over_r;
    rise = '0;
    if (filt_valid[0])
    begin
      over_nxt = over; // RL18
      rise = over & ~over_r; // RL16
    end
    // Set wins over a clear in the same cycle
    pend_nxt = (pend_r & ~i_alarm_clear) | rise; // RL16 RL12 RL13
    // Forcing ignores the enables on purpose
    open_nxt = open_r;
    if (i_line_state_write)
      open_nxt = 1'b0; // RL11
    if (|rise)
      open_nxt = 1'b1; // RL10 RL11
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      over_r <= '0;
      pend_r <= '0;
      open_r <= 1'b0;
    end
    else
    begin
      over_r <= over_nxt;
      pend_r <= pend_nxt;
      open_r <= open_nxt;
    end
  end

  // Read-back: total power and programmed values
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  always_comb
  begin
    unique case (i_loc_addr)
      LOC_TOTAL_SUM: rdata_nxt = total; // RL14 RL2
      LOC_THR12: rdata_nxt = thr_r[0];
      LOC_THR34: rdata_nxt = thr_r[1];
      LOC_THR56: rdata_nxt = thr_r[2];
      LOC_POLE12: rdata_nxt = pole_r[0];
      LOC_POLE34: rdata_nxt = pole_r[1];
      LOC_POLE56: rdata_nxt = pole_r[2];
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      rdata_r <= '0;
    else
      rdata_r <= rdata_nxt;
  end

  // Outputs
  assign o_loc_rdata = rdata_r;
  assign o_transistor_alarm_pending = pend_r;
  assign o_alarm_request = |(pend_r & i_transistor_alarm_enable); // RL12 RL13
  assign o_line_open = open_r;
  assign o_companion_mode = mode_r;

endmodule

// *** lpa_linefeed_power_alarm_properties.sv ***
// Port-level assertions for the power alarm block.
// Bound to every instance; sees its ports only.
`timescale 1ns/100ps
module lpa_props
  import lpa_pkg::*;
#(
  parameter int unsigned TICK_PERIOD = TICK_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_loc_wr,
  input wire logic [2:0] i_loc_addr,
  input wire logic [15:0] i_loc_wdata,
  input wire logic [15:0] o_loc_rdata,
  input wire logic [NUM_Q-1:0] i_alarm_clear,
  input wire logic [NUM_Q-1:0] i_transistor_alarm_enable,
  input wire logic [NUM_Q-1:0] o_transistor_alarm_pending,
  input wire logic o_alarm_request,
  input wire logic i_line_state_write,
  input wire logic o_line_open,
  input wire logic o_companion_mode
);
  logic [NUM_Q-1:0] pend_q;
  logic [NUM_Q-1:0] new_set;
  logic [NUM_Q-1:0] kept;

  // Freshly set pending bits
  always_ff @(posedge i_clock)
    pend_q <= i_rst ? '0 : o_transistor_alarm_pending;
  assign new_set = o_transistor_alarm_pending & ~pend_q;
  assign kept = o_transistor_alarm_pending & ~i_alarm_clear;

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_open_on_alarm: assert property (new_set != '0 |-> o_line_open)
    else $error("line not open on alarm");
  a_request_gate: assert property (o_alarm_request ==
    |(o_transistor_alarm_pending & i_transistor_alarm_enable))
    else $error("request not gated by enables");
  a_pending_sticky: assert property (kept != '0 |=> (o_transistor_alarm_pending
    & $past(kept)) == $past(kept))
    else $error("pending bit lost without clear");
  a_open_holds: assert property (o_line_open && !i_line_state_write |=> o_line_open)
    else $error("open state dropped");
  a_single_bit: assert property (o_companion_mode && $past(o_companion_mode, 4)
    |-> new_set[5:1] == '0)
    else $error("companion alarm on other bit");
  a_one_per_tick: assert property (new_set != '0 |=> (new_set == '0) [*8])
    else $error("alarm set twice in one update");
  a_idle_read: assert property (i_loc_addr == 3'h7 |=> o_loc_rdata == 16'h0000)
    else $error("unused location not zero");
  a_write_read: assert property (i_loc_wr && i_loc_addr inside {[3'h1:3'h6]}
    ##1 i_loc_addr == $past(i_loc_addr) && !i_loc_wr |=> o_loc_rdata == $past(i_loc_wdata, 2))
    else $error("written value not read back");
endmodule

bind lpa_linefeed_power_alarm lpa_props #(.TICK_PERIOD(TICK_PERIOD)) u_lpa_props (
  .i_clock, .i_rst, .i_loc_wr, .i_loc_addr, .i_loc_wdata, .o_loc_rdata, .i_alarm_clear,
  .i_transistor_alarm_enable, .o_transistor_alarm_pending, .o_alarm_request,
  .i_line_state_write, .o_line_open, .o_companion_mode);

// *** lpa_lf_model.sv ***
// Behavioural linefeed: fixed voltages, one load current.
// Assumes the bench sets load and companion presence.
`timescale 1ns/100ps
module lpa_lf_model
  import lpa_pkg::*;
(
  input wire logic i_companion,
  input wire logic [15:0] i_load,
  input wire logic i_line_open,
  output lpa_sample_s o_sample,
  output logic o_thermal_sense_pin
);
  // Open line carries no current, as in the real circuit
  always_comb
  begin
    o_sample.vtip = 16'h1000;
    o_sample.vring = 16'h1000;
    o_sample.vbat = 16'h2000;
    for (int k = 0; k < NUM_Q; k++)
      o_sample.cur[k] = i_line_open ? 16'h0000 : i_load;
    o_thermal_sense_pin = i_companion;
  end
endmodule

// *** tb.sv ***
// Self-checking bench for the power alarm block.
// Assumes the checker binds itself; short tick period.
`timescale 1ns/100ps
module tb;
  import lpa_pkg::*;
  localparam int TP = 20;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic comp = 1'b0;
  logic [15:0] load = 16'h1000;
  lpa_sample_s smp;
  logic sense;
  logic wr = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [5:0] clr = 6'h00;
  logic [5:0] en = 6'h00;
  logic [5:0] pend;
  logic req;
  logic lsw = 1'b0;
  logic open;
  logic cmode;
  int miscompares = 0;
  int cmp_count = 0;
  logic [63:0] tot;

  // 200 MHz clock
  always #2.5 i_clock = ~i_clock;

  lpa_linefeed_power_alarm #(.TICK_PERIOD(TP)) u_lpa_linefeed_power_alarm (
    .i_clock(i_clock), .i_rst(i_rst), .i_sample(smp), .i_thermal_sense_pin(sense),
    .i_loc_wr(wr), .i_loc_addr(addr), .i_loc_wdata(wdata), .o_loc_rdata(rdata),
    .i_alarm_clear(clr), .i_transistor_alarm_enable(en), .o_transistor_alarm_pending(pend),
    .o_alarm_request(req), .i_line_state_write(lsw), .o_line_open(open),
    .o_companion_mode(cmode));
  lpa_lf_model u_lpa_lf_model (.i_companion(comp), .i_load(load), .i_line_open(open),
    .o_sample(smp), .o_thermal_sense_pin(sense));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Settle one step past the edge before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic wloc(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask
  task automatic rloc(input logic [2:0] a, output logic [15:0] d);
    @(posedge i_clock);
    addr <= a;
    cyc(1);
    d = rdata;
  endtask
  task automatic pulse(input logic [5:0] m, input logic s);
    @(posedge i_clock);
    clr <= m;
    lsw <= s;
    @(posedge i_clock);
    clr <= 6'h00;
    lsw <= 1'b0;
    cyc(2);
  endtask
  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    #100000;
    miscompares++;
    conclude();
  end

  // Main sequence
  initial
  begin
    logic [15:0] v;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int a = 1; a < 8; a++)
    begin
      rloc(a[2:0], v);
      check(v, a == 7 ? 16'h0000 : (a < 4 ? THR_RESET : POLE_RESET));
    end
    for (int a = 1; a < 7; a++)
    begin
      // High thresholds and negative poles so no stray alarm fires here
      wloc(a[2:0], 16'(16'hf000 + a * 8));
      rloc(a[2:0], v);
      check(v, 16'(16'hf000 + a * 8));
    end
    // Companion mode: total of six estimates
    wloc(LOC_POLE12, 16'h7ff8);
    wloc(LOC_THR12, 16'hffff);
    comp <= 1'b1;
    cyc(4 * TP);
    check({15'h0, cmode}, 16'h0001);
    wloc(LOC_TOTAL_SUM, 16'h0000);
    rloc(LOC_TOTAL_SUM, v);
    tot = (64'(load) * 64'h8264 * 64'h0000f09f) >> 32;
    check(v, tot[15:0]);
    wloc(LOC_THR12, 16'(tot[15:1]));
    cyc(4 * TP);
    check({10'h0, pend}, 16'h0001);
    check({14'h0, req, open}, 16'h0001);
    @(posedge i_clock);
    en <= 6'h3f;
    cyc(2);
    check({15'h0, req}, 16'h0001);
    wloc(LOC_THR12, 16'hffff);
    pulse(6'h3f, 1'b1);
    cyc(4 * TP);
    check({9'h0, req, pend, open}, 16'h0000);
    // Discrete mode: per-pair poles and thresholds
    comp <= 1'b0;
    wloc(LOC_POLE34, 16'h0000);
    wloc(LOC_THR34, 16'h0001);
    wloc(LOC_THR56, 16'h0001);
    wloc(LOC_POLE56, 16'h7ff8);
    cyc(4 * TP);
    check({9'h0, cmode, pend, open}, 16'h0061);
    wloc(LOC_POLE34, 16'h7ff8);
    pulse(6'h00, 1'b1);
    cyc(4 * TP);
    check({9'h0, cmode, pend, open}, 16'h0079);
    pulse(6'h0c, 1'b0);
    check({10'h0, pend}, 16'h0030);
    conclude();
  end
endmodule
